/* patm_bus_model.sv */
// Bus initiator model: address phase, one data phase, then a released bus.
`timescale 1ns/1ns
module patm_bus_model (
    input wire logic CLK,
    output logic FRAME_N,
    output logic [31:0] AD,
    output logic [3:0] CBE_N
);
    int ph = 0;
    logic [3:0] q_cmd = 4'h0;
    logic [31:0] q_addr = 32'h0;
    initial begin
        FRAME_N = 1'b1;
        AD = 32'h5a5a_5a5a;
        CBE_N = 4'ha;
    end
    // No target claims anything here; the monitor must snoop regardless.
    // Released lines toggle every cycle so a stale address can never look valid.
    always @(posedge CLK) begin
        #1;
        if (ph == 1) begin
            FRAME_N = 1'b0;
            AD = q_addr;
            CBE_N = q_cmd;
        end else if (ph == 2) begin
            FRAME_N = 1'b1;
            AD = ~q_addr;
            CBE_N = 4'h0;
        end else begin
            AD = ~AD;
            CBE_N = ~CBE_N;
        end
        if (ph != 0) ph = (ph == 2) ? 0 : ph + 1;
    end
    task issue(input logic [3:0] cmd, input logic [31:0] addr);
        q_cmd = cmd;
        q_addr = addr;
        ph = 1;
        repeat (2) @(posedge CLK);
    endtask : issue
endmodule : patm_bus_model

/* patm_pkg.sv */
// Constants shared by the address trap monitor: register map, reset values and bus commands.
package patm_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int NUM_REGS = 15;
    localparam logic [7:0] REG_FIRST = 8'ha0;
    localparam logic [7:0] REG_LAST = 8'hd8;
    localparam logic [7:0] SERIAL_TRAP_ADDRESS = 8'ha0;
    localparam logic [7:0] SERIAL_TRAP_MASK = 8'ha4;
    localparam logic [7:0] AUDIO_TRAP_ADDRESS_LOW = 8'ha8;
    localparam logic [7:0] AUDIO_TRAP_ADDRESS_HIGH = 8'hac;
    localparam logic [7:0] AUDIO_TRAP_MASK = 8'hb0;
    localparam logic [7:0] CARD_TRAP_IO_ADDRESS = 8'hb4;
    localparam logic [7:0] CARD1_TRAP_MEMORY_ADDRESS = 8'hb8;
    localparam logic [7:0] CARD2_TRAP_MEMORY_ADDRESS = 8'hbc;
    localparam logic [7:0] CARD_TRAP_MASK = 8'hc0;
    localparam logic [7:0] IO_MONITOR_ADDRESS_LOW = 8'hc4;
    localparam logic [7:0] IO_MONITOR_ADDRESS_HIGH = 8'hc8;
    localparam logic [7:0] IO_MONITOR_MASK = 8'hcc;
    localparam logic [7:0] MEMORY_MONITOR1_ADDRESS = 8'hd0;
    localparam logic [7:0] MEMORY_MONITOR2_ADDRESS = 8'hd4;
    localparam logic [7:0] MEMORY_MONITOR_MASK = 8'hd8;

    // Word indices, counted from the first register.
    localparam int IDX_SER_ADDR = 0;
    localparam int IDX_SER_MASK = 1;
    localparam int IDX_AUD_LO = 2;
    localparam int IDX_AUD_HI = 3;
    localparam int IDX_AUD_MASK = 4;
    localparam int IDX_CARD_IO = 5;
    localparam int IDX_CARD1_MEM = 6;
    localparam int IDX_CARD2_MEM = 7;
    localparam int IDX_CARD_MASK = 8;
    localparam int IDX_IOM_LO = 9;
    localparam int IDX_IOM_HI = 10;
    localparam int IDX_IOM_MASK = 11;
    localparam int IDX_MEM1 = 12;
    localparam int IDX_MEM2 = 13;
    localparam int IDX_MEM_MASK = 14;

    localparam logic [31:0] REG_RESET [NUM_REGS] = '{
        32'h02f803f8, 32'h00000f0f, 32'h03300220, 32'h03880530, 32'h0707010f,
        32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
        32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000
    };

    // Writable bits; reserved and unimplemented bits stay zero.
    localparam logic [31:0] REG_WMASK [NUM_REGS] = '{
        32'hffffffff, 32'h0000ffff, 32'hffffffff, 32'hffffffff, 32'hffffffff,
        32'hffffffff, 32'hfffffc00, 32'hfffffc00, 32'hffffffff, 32'hffffffff,
        32'hffffffff, 32'hffffffff, 32'hffffff00, 32'hffffff00, 32'hffffffff
    };

    // ------------------------------------------------------------------
    // Bus commands, as driven on the command/byte-enable lines
    // ------------------------------------------------------------------
    localparam logic [3:0] CMD_IO_READ = 4'h2;
    localparam logic [3:0] CMD_IO_WRITE = 4'h3;
    localparam logic [3:0] CMD_MEM_READ = 4'h6;
    localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
    localparam logic [3:0] CMD_MEM_READ_MULT = 4'hc;
    localparam logic [3:0] CMD_MEM_READ_LINE = 4'he;
    localparam logic [3:0] CMD_MEM_WRITE_INV = 4'hf;

    localparam int NUM_IO_CMP = 12;

endpackage : patm_pkg

/* patm_trap_monitor.sv */
// Bus address trap monitor: snooped address phases against masked windows.
// ----------------------------------------------------------------------
// Notes on behaviour
// - Serial traps match masked 16-bit IO address.
// - Every observed IO or memory address phase checked, any target.
// - Serial masks act on bits 7:0 only.
// - Serial address: second port high, first low.
// - Serial mask: second 15:8, first 7:0.
// - Audio event when any four windows match.
// - Audio address words: lower window low half.
// - Audio masks packed window four down one.
// - Card traps match IO or memory bits 31:10.
// - Card IO masks 7:0, memory masks 17:10.
// - Card memory address in 31:10, low reserved.
// - Card mask register packs memory and IO masks.
// - Four IO range monitors, masked IO compare.
// - Monitor masks 7:0, three/four extend 10:8.
// - Monitor addresses paired, masks packed four down.
// - Memory monitors compare bits 31:8, mask 23:8.
// - Memory monitor address in 31:8, low reserved.
// - Memory monitor mask: two high, one low.
// - Every trap event is a module output.
// ----------------------------------------------------------------------
`timescale 1ns/1ns

// ----------------------------------------------------------------------
// Masked comparator
// ----------------------------------------------------------------------
module patm_cmp #(
    parameter int W = 16
) (
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    input wire logic [W-1:0] m,
    output logic hit
);
    // Mask bits set to one are forced equal on both sides.
    assign hit = ((a | m) == (b | m));
endmodule : patm_cmp

// ----------------------------------------------------------------------
// Top
// ----------------------------------------------------------------------
module patm_trap_monitor (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic FRAME_N,
    input wire logic [31:0] AD,
    input wire logic [3:0] CBE_N,
    input wire logic CFG_WR,
    input wire logic CFG_RD,
    input wire logic [7:0] CFG_ADDR,
    input wire logic [3:0] CFG_BE,
    input wire logic [31:0] CFG_WDATA,
    output logic [31:0] CFG_RDATA,
    input wire logic [2:0] IOMON3_MASK_EXTEND,
    input wire logic [2:0] IOMON4_MASK_EXTEND,
    output logic SERIAL_FIRST_EVT,
    output logic SERIAL_SECOND_EVT,
    output logic AUDIO_EVT,
    output logic CARD1_EVT,
    output logic CARD2_EVT,
    output logic [3:0] IOMON_EVT,
    output logic [1:0] MEMMON_EVT
);
    import patm_pkg::*;

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    logic [31:0] cfg_reg [NUM_REGS];
    logic [31:0] rdata_reg;
    wire [7:0] cfg_off = CFG_ADDR - REG_FIRST;
    wire [3:0] cfg_idx = cfg_off[5:2];
    wire cfg_hit = (CFG_ADDR >= REG_FIRST) && (CFG_ADDR <= REG_LAST) && (CFG_ADDR[1:0] == 2'h0);
    wire [31:0] be_bits = {{8{CFG_BE[3]}}, {8{CFG_BE[2]}}, {8{CFG_BE[1]}}, {8{CFG_BE[0]}}};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
            wire wr_sel = CFG_WR && cfg_hit && (cfg_idx == 4'(gi));
            wire [31:0] merged = (cfg_reg[gi] & ~be_bits) | (CFG_WDATA & be_bits);
            always_ff @(posedge CLK or negedge RST_N) begin
                if (!RST_N) begin
                    cfg_reg[gi] <= REG_RESET[gi];
                end else if (wr_sel) begin
                    // Reserved bits are held at zero.
                    cfg_reg[gi] <= merged & REG_WMASK[gi];
                end
            end
        end
    endgenerate

    // Unmapped offsets read as zero.
    wire [31:0] rdata_next = cfg_hit ? cfg_reg[cfg_idx] : 32'h00000000;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_reg <= 32'h00000000;
        end else if (CFG_RD) begin
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------------
    // Bus snoop stages
    // ------------------------------------------------------------------
    // Two register stages keep the comparators off the raw pins; the added
    // latency is harmless because events are only consumed by slow logic.
    logic frame_s1_reg, frame_s2_reg, frame_prev_reg;
    logic [31:0] ad_s1_reg, ad_s2_reg;
    logic [3:0] cmd_s1_reg, cmd_s2_reg;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            frame_s1_reg <= 1'b1;
            frame_s2_reg <= 1'b1;
            frame_prev_reg <= 1'b1;
            ad_s1_reg <= 32'h00000000;
            ad_s2_reg <= 32'h00000000;
            cmd_s1_reg <= 4'h0;
            cmd_s2_reg <= 4'h0;
        end else begin
            frame_s1_reg <= FRAME_N;
            frame_s2_reg <= frame_s1_reg;
            frame_prev_reg <= frame_s2_reg;
            ad_s1_reg <= AD;
            ad_s2_reg <= ad_s1_reg;
            cmd_s1_reg <= CBE_N;
            cmd_s2_reg <= cmd_s1_reg;
        end
    end

    // The address phase is the first clock with the frame asserted; no target
    // decode is involved, so cycles for other targets are seen too.
    wire addr_phase = frame_prev_reg && !frame_s2_reg;
    wire is_io = (cmd_s2_reg == CMD_IO_READ) || (cmd_s2_reg == CMD_IO_WRITE);
    wire is_mem = (cmd_s2_reg == CMD_MEM_READ) || (cmd_s2_reg == CMD_MEM_WRITE)
        || (cmd_s2_reg == CMD_MEM_READ_MULT) || (cmd_s2_reg == CMD_MEM_READ_LINE)
        || (cmd_s2_reg == CMD_MEM_WRITE_INV);
    wire io_phase = addr_phase && is_io;
    wire mem_phase = addr_phase && is_mem;

    // ------------------------------------------------------------------
    // IO windows: serial 0-1, audio 2-5, card 6-7, range monitors 8-11
    // ------------------------------------------------------------------
    logic [15:0] io_addr [NUM_IO_CMP];
    logic [15:0] io_mask [NUM_IO_CMP];
    logic [NUM_IO_CMP-1:0] io_hit;

    assign io_addr[0] = cfg_reg[IDX_SER_ADDR][15:0];
    assign io_addr[1] = cfg_reg[IDX_SER_ADDR][31:16];
    assign io_mask[0] = {8'h00, cfg_reg[IDX_SER_MASK][7:0]};
    assign io_mask[1] = {8'h00, cfg_reg[IDX_SER_MASK][15:8]};
    assign io_addr[2] = cfg_reg[IDX_AUD_LO][15:0];
    assign io_addr[3] = cfg_reg[IDX_AUD_LO][31:16];
    assign io_addr[4] = cfg_reg[IDX_AUD_HI][15:0];
    assign io_addr[5] = cfg_reg[IDX_AUD_HI][31:16];
    assign io_mask[2] = {8'h00, cfg_reg[IDX_AUD_MASK][7:0]};
    assign io_mask[3] = {8'h00, cfg_reg[IDX_AUD_MASK][15:8]};
    assign io_mask[4] = {8'h00, cfg_reg[IDX_AUD_MASK][23:16]};
    assign io_mask[5] = {8'h00, cfg_reg[IDX_AUD_MASK][31:24]};
    assign io_addr[6] = cfg_reg[IDX_CARD_IO][15:0];
    assign io_addr[7] = cfg_reg[IDX_CARD_IO][31:16];
    assign io_mask[6] = {8'h00, cfg_reg[IDX_CARD_MASK][7:0]};
    assign io_mask[7] = {8'h00, cfg_reg[IDX_CARD_MASK][15:8]};
    assign io_addr[8] = cfg_reg[IDX_IOM_LO][15:0];
    assign io_addr[9] = cfg_reg[IDX_IOM_LO][31:16];
    assign io_addr[10] = cfg_reg[IDX_IOM_HI][15:0];
    assign io_addr[11] = cfg_reg[IDX_IOM_HI][31:16];
    assign io_mask[8] = {8'h00, cfg_reg[IDX_IOM_MASK][7:0]};
    assign io_mask[9] = {8'h00, cfg_reg[IDX_IOM_MASK][15:8]};
    assign io_mask[10] = {5'h00, IOMON3_MASK_EXTEND, cfg_reg[IDX_IOM_MASK][23:16]};
    assign io_mask[11] = {5'h00, IOMON4_MASK_EXTEND, cfg_reg[IDX_IOM_MASK][31:24]};

    generate
        for (gi = 0; gi < NUM_IO_CMP; gi++) begin : g_io
            patm_cmp #(.W(16)) u_cmp (
                .a(ad_s2_reg[15:0]),
                .b(io_addr[gi]),
                .m(io_mask[gi]),
                .hit(io_hit[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Memory windows
    // ------------------------------------------------------------------
    logic [1:0] card_mem_hit;
    logic [1:0] mon_mem_hit;
    logic [21:0] card_mem_addr [2];
    logic [21:0] card_mem_mask [2];
    logic [23:0] mon_mem_addr [2];
    logic [23:0] mon_mem_mask [2];

    assign card_mem_addr[0] = cfg_reg[IDX_CARD1_MEM][31:10];
    assign card_mem_addr[1] = cfg_reg[IDX_CARD2_MEM][31:10];
    assign card_mem_mask[0] = {14'h0000, cfg_reg[IDX_CARD_MASK][23:16]};
    assign card_mem_mask[1] = {14'h0000, cfg_reg[IDX_CARD_MASK][31:24]};
    assign mon_mem_addr[0] = cfg_reg[IDX_MEM1][31:8];
    assign mon_mem_addr[1] = cfg_reg[IDX_MEM2][31:8];
    assign mon_mem_mask[0] = {8'h00, cfg_reg[IDX_MEM_MASK][15:0]};
    assign mon_mem_mask[1] = {8'h00, cfg_reg[IDX_MEM_MASK][31:16]};

    generate
        for (gi = 0; gi < 2; gi++) begin : g_mem
            patm_cmp #(.W(22)) u_card (
                .a(ad_s2_reg[31:10]),
                .b(card_mem_addr[gi]),
                .m(card_mem_mask[gi]),
                .hit(card_mem_hit[gi])
            );
            patm_cmp #(.W(24)) u_mon (
                .a(ad_s2_reg[31:8]),
                .b(mon_mem_addr[gi]),
                .m(mon_mem_mask[gi]),
                .hit(mon_mem_hit[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Event outputs
    // ------------------------------------------------------------------
    logic ser1_reg, ser2_reg, audio_reg, card1_reg, card2_reg;
    logic [3:0] iomon_reg;
    logic [1:0] memmon_reg;

    wire ser1_next = io_phase && io_hit[0];
    wire ser2_next = io_phase && io_hit[1];
    wire audio_next = io_phase && (|io_hit[5:2]);
    wire card1_next = (io_phase && io_hit[6]) || (mem_phase && card_mem_hit[0]);
    wire card2_next = (io_phase && io_hit[7]) || (mem_phase && card_mem_hit[1]);
    wire [3:0] iomon_next = io_phase ? io_hit[11:8] : 4'h0;
    wire [1:0] memmon_next = mem_phase ? mon_mem_hit : 2'h0;

    // Each event is high for exactly the one clock after its address phase.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ser1_reg <= 1'b0;
            ser2_reg <= 1'b0;
            audio_reg <= 1'b0;
            card1_reg <= 1'b0;
            card2_reg <= 1'b0;
            iomon_reg <= 4'h0;
            memmon_reg <= 2'h0;
        end else begin
            ser1_reg <= ser1_next;
            ser2_reg <= ser2_next;
            audio_reg <= audio_next;
            card1_reg <= card1_next;
            card2_reg <= card2_next;
            iomon_reg <= iomon_next;
            memmon_reg <= memmon_next;
        end
    end

    assign CFG_RDATA = rdata_reg;
    assign SERIAL_FIRST_EVT = ser1_reg;
    assign SERIAL_SECOND_EVT = ser2_reg;
    assign AUDIO_EVT = audio_reg;
    assign CARD1_EVT = card1_reg;
    assign CARD2_EVT = card2_reg;
    assign IOMON_EVT = iomon_reg;
    assign MEMMON_EVT = memmon_reg;

endmodule : patm_trap_monitor

/* patm_trap_monitor_asserts.sv */
// Concurrent checks on the trap monitor's event and read-data ports.
`timescale 1ns/1ns
module patm_trap_monitor_chk
    import patm_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic FRAME_N,
    input wire logic [3:0] CBE_N,
    input wire logic CFG_RD,
    input wire logic [31:0] CFG_RDATA,
    input wire logic SERIAL_FIRST_EVT,
    input wire logic SERIAL_SECOND_EVT,
    input wire logic AUDIO_EVT,
    input wire logic CARD1_EVT,
    input wire logic CARD2_EVT,
    input wire logic [3:0] IOMON_EVT,
    input wire logic [1:0] MEMMON_EVT
);
    wire logic is_io = CBE_N inside {CMD_IO_READ, CMD_IO_WRITE};
    wire logic is_mem = CBE_N inside {CMD_MEM_READ, CMD_MEM_WRITE, CMD_MEM_READ_MULT,
        CMD_MEM_READ_LINE, CMD_MEM_WRITE_INV};
    wire logic any_evt = SERIAL_FIRST_EVT | SERIAL_SECOND_EVT | AUDIO_EVT | CARD1_EVT
        | CARD2_EVT | (|IOMON_EVT) | (|MEMMON_EVT);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // Events trail the address phase by three edges, so its command is looked up that far back.
    a_serial_first_io: assert property (SERIAL_FIRST_EVT |-> $past(is_io, 3))
        else $error("serial first event without an IO cycle");
    a_serial_second_io: assert property (SERIAL_SECOND_EVT |-> $past(is_io, 3))
        else $error("serial second event without an IO cycle");
    a_audio_io: assert property (AUDIO_EVT |-> $past(is_io, 3))
        else $error("audio event without an IO cycle");
    a_card_space: assert property ((CARD1_EVT | CARD2_EVT) |-> $past(is_io | is_mem, 3))
        else $error("card event without an IO or memory cycle");
    a_iomon_io: assert property ((|IOMON_EVT) |-> $past(is_io, 3))
        else $error("IO monitor event without an IO cycle");
    a_memmon_mem: assert property ((|MEMMON_EVT) |-> $past(is_mem, 3))
        else $error("memory monitor event without a memory cycle");
    a_event_phase: assert property (any_evt |-> !$past(FRAME_N, 3) && $past(FRAME_N, 4))
        else $error("event not three edges after a frame start");
    a_event_single: assert property (any_evt |=> !any_evt)
        else $error("event held longer than one cycle");
    a_rdata_hold: assert property (!CFG_RD |=> $stable(CFG_RDATA))
        else $error("read data changed without a read");
endmodule : patm_trap_monitor_chk

bind patm_trap_monitor patm_trap_monitor_chk chk_u (.CLK(CLK), .RST_N(RST_N), .FRAME_N(FRAME_N),
    .CBE_N(CBE_N), .CFG_RD(CFG_RD), .CFG_RDATA(CFG_RDATA), .SERIAL_FIRST_EVT(SERIAL_FIRST_EVT),
    .SERIAL_SECOND_EVT(SERIAL_SECOND_EVT), .AUDIO_EVT(AUDIO_EVT), .CARD1_EVT(CARD1_EVT),
    .CARD2_EVT(CARD2_EVT), .IOMON_EVT(IOMON_EVT), .MEMMON_EVT(MEMMON_EVT));

/* tb_patm_trap_monitor.sv */
// Self-checking bench for the address trap monitor.
`timescale 1ns/1ns
module tb_patm_trap_monitor;
    import patm_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cfg_wr = 1'b0;
    logic cfg_rd = 1'b0;
    logic [7:0] cfg_addr = 8'ha0;
    logic [3:0] cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h0;
    logic [31:0] cfg_rdata;
    logic [2:0] ext3 = 3'h0;
    logic [2:0] ext4 = 3'h0;
    wire logic frame_n;
    wire logic [31:0] ad;
    wire logic [3:0] cbe_n;
    wire logic [10:0] evt;
    int n_mismatch = 0;
    int n_compared = 0;
    logic [15:0] lf = 16'h0028;
    logic [31:0] mir [NUM_REGS];
    logic [3:0] cmds [12] = '{4'h2, 4'h3, 4'h6, 4'h7, 4'hc, 4'he, 4'hf, 4'h0, 4'h1, 4'ha, 4'hb, 4'hd};
    patm_bus_model bus_u (.CLK(clk), .FRAME_N(frame_n), .AD(ad), .CBE_N(cbe_n));
    patm_trap_monitor dut_u (.CLK(clk), .RST_N(rst_n), .FRAME_N(frame_n), .AD(ad), .CBE_N(cbe_n),
        .CFG_WR(cfg_wr), .CFG_RD(cfg_rd), .CFG_ADDR(cfg_addr), .CFG_BE(cfg_be),
        .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata), .IOMON3_MASK_EXTEND(ext3),
        .IOMON4_MASK_EXTEND(ext4), .SERIAL_FIRST_EVT(evt[0]), .SERIAL_SECOND_EVT(evt[1]),
        .AUDIO_EVT(evt[2]), .CARD1_EVT(evt[3]), .CARD2_EVT(evt[4]), .IOMON_EVT(evt[8:5]),
        .MEMMON_EVT(evt[10:9]));
    initial forever #50 clk = ~clk;
    initial begin
        #9000000;
        n_mismatch++;
        finish_test();
    end
    function logic [15:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction : rnd
    function automatic logic hit(logic [31:0] a, logic [31:0] b, logic [31:0] k);
        return (a | k) == (b | k);
    endfunction : hit
    function automatic logic [10:0] expect_evt(logic [3:0] c, logic [31:0] a);
        logic io;
        logic mem;
        logic [10:0] e;
        io = c inside {CMD_IO_READ, CMD_IO_WRITE};
        mem = c inside {CMD_MEM_READ, CMD_MEM_WRITE, CMD_MEM_READ_MULT, CMD_MEM_READ_LINE,
            CMD_MEM_WRITE_INV};
        e = '0;
        e[0] = io & hit(a[15:0], mir[0][15:0], mir[1][7:0]);
        e[1] = io & hit(a[15:0], mir[0][31:16], mir[1][15:8]);
        for (int i = 0; i < 4; i++) begin
            e[2] |= io & hit(a[15:0], mir[2 + i / 2][16 * (i % 2) +: 16], mir[4][8 * i +: 8]);
            e[5 + i] = io & hit(a[15:0], mir[9 + i / 2][16 * (i % 2) +: 16],
                {(i == 2) ? ext3 : ((i == 3) ? ext4 : 3'h0), mir[11][8 * i +: 8]});
        end
        for (int i = 0; i < 2; i++) begin
            e[3 + i] = (io & hit(a[15:0], mir[5][16 * i +: 16], mir[8][8 * i +: 8]))
                | (mem & hit(a[31:10], mir[6 + i][31:10], mir[8][16 + 8 * i +: 8]));
            e[9 + i] = mem & hit(a[31:8], mir[12 + i][31:8], mir[14][16 * i +: 16]);
        end
        return e;
    endfunction : expect_evt
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Called on a clock edge; strobes stay up across back-to-back calls.
    task cfg(input logic wr, input logic rd, input logic [7:0] a, input logic [3:0] be,
        input logic [31:0] d);
        #1 cfg_wr = wr;
        cfg_rd = rd;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = d;
        @(posedge clk);
    endtask : cfg
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [3:0] be;
        logic [31:0] bm;
        int i;
        be = 4'(rnd());
        bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        i = (int'(a) - 32'ha0) / 4;
        if (a >= REG_FIRST && a <= REG_LAST && a[1:0] == 2'b00)
            mir[i] = (mir[i] & ~(bm & REG_WMASK[i])) | (d & bm & REG_WMASK[i]);
        cfg(1'b1, 1'b0, a, be, d);
    endtask : wr
    task rd_all();
        for (int i = 0; i < 17; i++) begin
            cfg(1'b0, 1'b1, 8'(32'ha0 + 4 * i), 4'h0, 32'h0);
            cfg(1'b0, 1'b0, 8'ha2, 4'h0, 32'h0);
            chk("register", (i < NUM_REGS) ? mir[i] : 32'h0, cfg_rdata);
        end
        cfg(1'b0, 1'b1, 8'ha2, 4'h0, 32'h0);
        cfg(1'b0, 1'b0, 8'ha2, 4'h0, 32'h0);
        chk("misaligned", 32'h0, cfg_rdata);
    endtask : rd_all
    task snoop(input logic [3:0] c, input logic [31:0] a);
        logic [10:0] e;
        @(posedge clk);
        #1 ext3 = 3'(rnd());
        ext4 = 3'(rnd());
        e = expect_evt(c, a);
        #1 bus_u.issue(c, a);
        repeat (2) @(posedge clk);
        #2 chk("events", 32'(e), 32'(evt));
        @(posedge clk);
        #2 chk("events after pulse", 32'h0, 32'(evt));
    endtask : snoop
    task finish_test();
        $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test
    initial begin
        logic [31:0] base;
        for (int i = 0; i < NUM_REGS; i++) mir[i] = REG_RESET[i];
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        @(posedge clk);
        rd_all();
        snoop(CMD_IO_READ, 32'h0000_03f8);
        snoop(CMD_IO_WRITE, 32'h0000_02ff);
        snoop(CMD_IO_READ, 32'h0001_13f8);
        snoop(CMD_MEM_READ, 32'h0000_03f8);
        snoop(4'ha, 32'h0000_0220);
        $display("test default traps done");
        for (int r = 0; r < 8; r++) begin
            if (r == 4) begin
                @(posedge clk);
                #1 rst_n = 1'b0;
                #2 chk("events in reset", 32'h0, 32'(evt));
                chk("read data in reset", 32'h0, cfg_rdata);
                for (int i = 0; i < NUM_REGS; i++) mir[i] = REG_RESET[i];
                repeat (4) @(posedge clk);
                #1 rst_n = 1'b1;
                @(posedge clk);
                rd_all();
            end
            for (int i = 0; i < 17; i++) wr(8'(32'ha0 + 4 * i), {rnd(), rnd()});
            wr(8'ha6, {rnd(), rnd()});
            rd_all();
            for (int i = 0; i < 80; i++) begin
                base = mir[rnd() % NUM_REGS];
                snoop(cmds[rnd() % 12], (lf[0] ? base : {base[15:0], base[31:16]})
                    ^ ({rnd(), rnd()} & 32'h0000_070f));
            end
            $display("test random round %0d done", r);
        end
        finish_test();
    end
endmodule : tb_patm_trap_monitor
